//--- verilog/brc_rtc_core.sv
// real-time clock core: calendar, alarms, periodic interrupt, supply and oscillator monitors
// ********************************
// Overview of operation
// - main supply feeds core unless below detect
// - supply-low output low while main supply low
// - supply-low release waits fixed delay after rise
// - release delay 100 to 110 ms, 105 typical
// - serial access stops while main supply low
// - data line open drain, never driven high
// - host reads and writes each time unit
// - years divisible by four are leap years
// - weekly alarm matches minute, hour, weekday set
// - daily alarm matches hour and minute only
// - both alarms share one active-low interrupt
// - each alarm keeps a pollable flag
// - rate trim in 3 or 1 ppm steps
// - cold power-up resets control registers
// - cold power-up sets sticky power-on flag
// - oscillator halt latches a readable flag
// - supply monitor samples each second, latches drop
// - periodic rates 2 Hz to monthly
// - pulse waveform for 2/1 Hz, else level
// - periodic state readable as a flag
// - 32 kHz clock always driven out
// ********************************
`timescale 1ns/100ps
module brc_rtc_core
  import brc_pkg::*;
#(
  parameter int         RELEASE_CYC = RELEASE_DELAY_CYC,
  parameter logic [6:0] DEV_ADDR    = 7'h5a  // arbitrary bus address
)
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic osc32k,
  input  wire logic mainAboveDetect,
  input  wire logic mainAboveRelease,
  input  wire logic vddAboveHigh,
  input  wire logic vddAboveLow,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sdaDrv,
  output logic      sdaOe,
  output logic      useBackupSupply,
  output logic      mainSupplyLowOut,
  output logic      mainSupplyLowOe,
  output logic      irqNOut,
  output logic      irqNOe,
  output logic      khz32Out
);

  localparam logic [22:0]        REL_LAST  = 23'(RELEASE_CYC - 1);
  localparam logic [11:0]        HALT_LAST = 12'(HALT_CYC);
  localparam logic signed [15:0] HALF_LAST = 16'(HALF_SEC_TICKS - 1);
  localparam logic signed [15:0] QUARTER   = 16'(HALF_SEC_TICKS / 2);
  localparam logic [5:0]         ADJ_CRS   = 6'(ADJ_COARSE_SEC - 1);
  localparam logic [5:0]         ADJ_FIN   = 6'(ADJ_FINE_SEC - 1);

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic                oscA, oscB, oscC;
    logic                mainA, mainB, riseA, riseB;
    logic                vhA, vhB, vlA, vlB;
    logic signed [15:0]  pre;
    logic                halfSec;
    logic [5:0]          adjCnt;
    logic [7:0]          sec, min, hour;
    logic [2:0]          week;
    logic [7:0]          day, month, year;
    logic [7:0]          adj, wMin, wHour;
    logic [6:0]          wDays;
    logic [7:0]          dMin, dHour, ctrl1;
    logic                vdsl, vdet, xst, ponClr, scratch1, ctfg, wafg, dafg;
    logic                almChk;
    logic [11:0]         haltCnt;
    logic [22:0]         relCnt;
    logic                supplyGood, useBackup, irqOe, khzOut;
  } brc_core_t;

  brc_core_t          s;
  brc_core_t          n;
  logic [1:0]         rstSync;
  logic               rstN;
  logic [3:0]         regAddr;
  logic               wrEn;
  logic [7:0]         wrData;
  logic [7:0]         rdData;
  logic               oscRise;
  logic               halfTick;
  logic               secTick;
  logic               minTick;
  logic               hourTick;
  logic               dayTick;
  logic               monthTick;
  logic               yearTick;
  logic               levelEv;
  logic               pulseLow;
  logic               adjNow;
  logic signed [15:0] adjOff;
  logic [2:0]         ct;

  // ********************************
  // calendar helpers
  // ********************************
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // any two-digit year divisible by four, 00 included
  function automatic logic isLeap(input logic [7:0] y);
    if (y[4])
      isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] lastDay(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:                      lastDay = isLeap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
      default:                    lastDay = 8'h31;
    endcase
  endfunction

  // ********************************
  // reset release
  // ********************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end

  assign rstN = rstSync[1];

  // ********************************
  // next state
  // ********************************
  always_comb
  begin
    n       = s;
    n.oscA  = osc32k;
    n.oscB  = s.oscA;
    n.oscC  = s.oscB;
    n.mainA = mainAboveDetect;
    n.mainB = s.mainA;
    n.riseA = mainAboveRelease;
    n.riseB = s.riseA;
    n.vhA   = vddAboveHigh;
    n.vhB   = s.vhA;
    n.vlA   = vddAboveLow;
    n.vlB   = s.vlA;
    n.khzOut = s.oscB;
    ct      = s.ctrl1[2:0];

    // time base: half seconds from crystal edges, trimmed at each adjust slot
    oscRise   = s.oscB & ~s.oscC;
    halfTick  = oscRise && (s.pre >= HALF_LAST);
    secTick   = halfTick && s.halfSec;
    minTick   = secTick && s.sec == SEC_MAX;
    hourTick  = minTick && s.min == SEC_MAX;
    dayTick   = hourTick && s.hour == HOUR_MAX;
    monthTick = dayTick && s.day == lastDay(s.month, s.year);
    yearTick  = monthTick && s.month == MONTH_MAX;
    adjNow    = s.adjCnt == (s.adj[ADJ_DEV] ? ADJ_FIN : ADJ_CRS);
    // two crystal ticks per step: ~3 ppm over 20 s, ~1 ppm over 60 s
    adjOff    = {{8{s.adj[6]}}, s.adj[6:0], 1'b0};
    if (oscRise)
      n.pre = halfTick ? ((secTick && adjNow) ? adjOff : 16'sh0000) : s.pre + 16'sh0001;
    if (halfTick)
      n.halfSec = ~s.halfSec;
    if (secTick)
      n.adjCnt = adjNow ? 6'h00 : s.adjCnt + 6'h01;

    // calendar chain
    if (secTick)
      n.sec = minTick ? 8'h00 : bcdInc(s.sec);
    if (minTick)
      n.min = hourTick ? 8'h00 : bcdInc(s.min);
    if (hourTick)
      n.hour = dayTick ? 8'h00 : bcdInc(s.hour);
    if (dayTick)
    begin
      n.week = (s.week == WEEK_MAX) ? 3'h0 : s.week + 3'h1;
      n.day  = monthTick ? 8'h01 : bcdInc(s.day);
    end
    if (monthTick)
      n.month = yearTick ? 8'h01 : bcdInc(s.month);
    if (yearTick)
      n.year = (s.year == YEAR_MAX) ? 8'h00 : bcdInc(s.year);
    // compare one cycle later, against the already advanced minute
    n.almChk = minTick;

    // oscillator watchdog
    if (oscRise)
      n.haltCnt = 12'h000;
    else if (s.haltCnt != HALT_LAST)
      n.haltCnt = s.haltCnt + 12'h001;

    // host writes; flag clears are and-masks so later sets still win
    if (wrEn)
      case (regAddr)
        REG_SEC:
        begin
          n.sec     = {1'b0, wrData[6:0]};
          n.pre     = 16'sh0000;
          n.halfSec = 1'b0;
        end
        REG_MIN:   n.min   = {1'b0, wrData[6:0]};
        REG_HOUR:  n.hour  = {2'b00, wrData[5:0]};
        REG_WEEK:  n.week  = wrData[2:0];
        REG_DAY:   n.day   = {2'b00, wrData[5:0]};
        REG_MONTH: n.month = {3'b000, wrData[4:0]};
        REG_YEAR:  n.year  = wrData;
        REG_ADJ:   n.adj   = wrData;
        REG_WMIN:  n.wMin  = {1'b0, wrData[6:0]};
        REG_WHOUR: n.wHour = {2'b00, wrData[5:0]};
        REG_WDAYS: n.wDays = wrData[6:0];
        REG_DMIN:  n.dMin  = {1'b0, wrData[6:0]};
        REG_DHOUR: n.dHour = {2'b00, wrData[5:0]};
        REG_CTRL1: n.ctrl1 = wrData;
        REG_CTRL2:
        begin
          n.vdsl     = wrData[C2_VDSL];
          n.vdet     = s.vdet & wrData[C2_VDET];
          n.xst      = wrData[C2_XST];
          n.ponClr   = s.ponClr | ~wrData[C2_PON];
          n.scratch1 = wrData[C2_SCR1];
          n.ctfg     = s.ctfg & wrData[C2_CTFG];
          n.wafg     = s.wafg & wrData[C2_WAFG];
          n.dafg     = s.dafg & wrData[C2_DAFG];
        end
        default:   n.adj = s.adj;
      endcase

    // hardware flag sets
    if (s.haltCnt == HALT_LAST)
      n.xst = 1'b0;
    if (secTick && (s.vdsl ? !s.vlB : !s.vhB))
      n.vdet = 1'b1;
    if (s.almChk && s.ctrl1[C1_WALE] && s.min == s.wMin && s.hour == s.wHour && s.wDays[s.week])
      n.wafg = 1'b1;
    if (s.almChk && s.ctrl1[C1_DALE] && s.min == s.dMin && s.hour == s.dHour)
      n.dafg = 1'b1;

    // periodic interrupt
    case (ct)
      CT_SEC:   levelEv = secTick;
      CT_MIN:   levelEv = minTick;
      CT_HOUR:  levelEv = hourTick;
      CT_MONTH: levelEv = monthTick;
      default:  levelEv = 1'b0;
    endcase
    pulseLow = (ct == CT_2HZ) ? (s.pre < QUARTER) : !s.halfSec;
    if (ct == CT_2HZ || ct == CT_1HZ)
      n.ctfg = pulseLow;
    else if (levelEv)
      n.ctfg = 1'b1;

    // shared interrupt line
    n.irqOe = (ct == CT_LOW) || (ct != CT_OFF && s.ctfg) ||
              (s.wafg && s.ctrl1[C1_WALE]) || (s.dafg && s.ctrl1[C1_DALE]);

    // main supply monitor and release delay
    n.useBackup = !s.mainB;
    if (!s.mainB)
    begin
      n.supplyGood = 1'b0;
      n.relCnt     = 23'h000000;
    end
    else if (!s.supplyGood)
    begin
      if (!s.riseB)
        n.relCnt = 23'h000000;
      else if (s.relCnt == REL_LAST)
        n.supplyGood = 1'b1;
      else
        n.relCnt = s.relCnt + 23'h000001;
    end
  end

  // cold power-up clears every field: control at default, power-on flag shown set
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      s <= '0;
    else
      s <= n;
  end

  // ********************************
  // register read
  // ********************************
  always_comb
  begin
    rdData = 8'h00;
    case (regAddr)
      REG_SEC:   rdData = s.sec;
      REG_MIN:   rdData = s.min;
      REG_HOUR:  rdData = s.hour;
      REG_WEEK:  rdData = {5'h00, s.week};
      REG_DAY:   rdData = s.day;
      REG_MONTH: rdData = s.month;
      REG_YEAR:  rdData = s.year;
      REG_ADJ:   rdData = s.adj;
      REG_WMIN:  rdData = s.wMin;
      REG_WHOUR: rdData = s.wHour;
      REG_WDAYS: rdData = {1'b0, s.wDays};
      REG_DMIN:  rdData = s.dMin;
      REG_DHOUR: rdData = s.dHour;
      REG_CTRL1: rdData = s.ctrl1;
      REG_CTRL2:
      begin
        rdData[C2_VDSL] = s.vdsl;
        rdData[C2_VDET] = s.vdet;
        rdData[C2_XST]  = s.xst;
        rdData[C2_PON]  = ~s.ponClr;
        rdData[C2_SCR1] = s.scratch1;
        rdData[C2_CTFG] = s.ctfg;
        rdData[C2_WAFG] = s.wafg;
        rdData[C2_DAFG] = s.dafg;
      end
      default:   rdData = 8'h00;
    endcase
  end

  // ********************************
  // serial host link
  // ********************************
  brc_serial_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .hostEn  (s.mainB),
    .scl     (scl),
    .sda     (sda),
    .sdaDrv  (sdaDrv),
    .sdaOe   (sdaOe),
    .regAddr (regAddr),
    .wrEn    (wrEn),
    .wrData  (wrData),
    .rdData  (rdData)
  );

  // open-drain pins only ever pull low
  assign useBackupSupply  = s.useBackup;
  assign mainSupplyLowOut = 1'b0;
  assign mainSupplyLowOe  = !s.supplyGood;
  assign irqNOut          = 1'b0;
  assign irqNOe           = s.irqOe;
  assign khz32Out         = s.khzOut;

  // ********************************
  // checks
  // ********************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  backup_select_a: assert property (!s.mainB |=> useBackupSupply)
    else $error("backup supply not selected below detect level");
  supply_low_a: assert property (!s.mainB |=> mainSupplyLowOe)
    else $error("supply-low pin released while supply is low");
  release_delay_a: assert property ($fell(mainSupplyLowOe) |-> $past(s.relCnt) == REL_LAST && s.riseB)
    else $error("supply-low pin released before full delay");
  leap_day_a: assert property (dayTick && !wrEn && s.month == 8'h02 && s.day == 8'h28
                               |=> s.day == (isLeap(s.year) ? 8'h29 : 8'h01))
    else $error("wrong day after february 28");
  alarm_minute_a: assert property ($rose(s.wafg) || $rose(s.dafg) |-> $past(s.almChk))
    else $error("alarm flag set away from a minute boundary");
  alarm_irq_a: assert property (s.dafg && s.ctrl1[C1_DALE] |=> irqNOe)
    else $error("enabled alarm flag not on interrupt line");
  halt_flag_a: assert property (s.haltCnt == HALT_LAST |=> !s.xst)
    else $error("oscillator halt not recorded");
  vdet_hold_a: assert property (s.vdet && !(wrEn && regAddr == REG_CTRL2) |=> s.vdet)
    else $error("supply drop flag lost without a host clear");
  clk_out_a: assert property ($past(rstN, 3) |-> khz32Out == $past(osc32k, 3))
    else $error("32 kHz output does not follow the crystal");

endmodule

//--- verilog/brc_pkg.sv
// shared constants of the battery-backed real-time clock core
package brc_pkg;

  // ********************************
  // clocks and timing
  // ********************************
  localparam int CLK_HZ            = 50_000_000;
  localparam int OSC_HZ            = 32768;
  localparam int HALF_SEC_TICKS    = OSC_HZ / 2;
  localparam int RELEASE_MIN_MS    = 100;
  localparam int RELEASE_MAX_MS    = 110;
  localparam int RELEASE_DELAY_MS  = 105;
  localparam int RELEASE_DELAY_CYC = RELEASE_DELAY_MS * (CLK_HZ / 1000);
  localparam int HALT_TIMEOUT_US   = 80;
  localparam int HALT_CYC          = HALT_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int ADJ_COARSE_SEC    = 20;
  localparam int ADJ_FINE_SEC      = 60;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [3:0] REG_SEC   = 4'h0;
  localparam logic [3:0] REG_MIN   = 4'h1;
  localparam logic [3:0] REG_HOUR  = 4'h2;
  localparam logic [3:0] REG_WEEK  = 4'h3;
  localparam logic [3:0] REG_DAY   = 4'h4;
  localparam logic [3:0] REG_MONTH = 4'h5;
  localparam logic [3:0] REG_YEAR  = 4'h6;
  localparam logic [3:0] REG_ADJ   = 4'h7;
  localparam logic [3:0] REG_WMIN  = 4'h8;
  localparam logic [3:0] REG_WHOUR = 4'h9;
  localparam logic [3:0] REG_WDAYS = 4'ha;
  localparam logic [3:0] REG_DMIN  = 4'hb;
  localparam logic [3:0] REG_DHOUR = 4'hc;
  localparam logic [3:0] REG_CTRL1 = 4'he;
  localparam logic [3:0] REG_CTRL2 = 4'hf;

  // ********************************
  // field positions and codes
  // ********************************
  localparam int C1_WALE  = 7;
  localparam int C1_DALE  = 6;
  localparam int ADJ_DEV  = 7;
  localparam int C2_VDSL  = 7;
  localparam int C2_VDET  = 6;
  localparam int C2_XST   = 5;
  localparam int C2_PON   = 4;
  localparam int C2_SCR1  = 3;
  localparam int C2_CTFG  = 2;
  localparam int C2_WAFG  = 1;
  localparam int C2_DAFG  = 0;

  localparam logic [2:0] CT_OFF   = 3'h0;
  localparam logic [2:0] CT_LOW   = 3'h1;
  localparam logic [2:0] CT_2HZ   = 3'h2;
  localparam logic [2:0] CT_1HZ   = 3'h3;
  localparam logic [2:0] CT_SEC   = 3'h4;
  localparam logic [2:0] CT_MIN   = 3'h5;
  localparam logic [2:0] CT_HOUR  = 3'h6;
  localparam logic [2:0] CT_MONTH = 3'h7;

  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [2:0] WEEK_MAX  = 3'h6;

endpackage

//--- verilog/brc_serial_slave.sv
// two-wire serial slave moving bytes between host and register file
`timescale 1ns/100ps
module brc_serial_slave
  import brc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h5a  // arbitrary bus address
)
(
  input  wire logic       clk_sys,
  input  wire logic       rstN,
  input  wire logic       hostEn,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sdaDrv,
  output logic            sdaOe,
  output logic [3:0]      regAddr,
  output logic            wrEn,
  output logic [7:0]      wrData,
  input  wire logic [7:0] rdData
);

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_AACK = 3'b010,
    SL_WRB  = 3'b011,
    SL_WACK = 3'b100,
    SL_RDB  = 3'b101,
    SL_RACK = 3'b110
  } brc_slave_state_t;

  typedef struct packed {
    logic             sclA, sclB, sclC, sdaA, sdaB, sdaC;
    brc_slave_state_t st;
    logic [3:0]       bitCnt;
    logic [7:0]       sh;
    logic [3:0]       ptr;
    logic             gotPtr, rw, nack, oe, wr;
  } brc_slave_t;

  brc_slave_t s;
  brc_slave_t n;
  logic       sclRise;
  logic       sclFall;
  logic       startC;
  logic       stopC;

  always_comb
  begin
    n       = s;
    n.wr    = 1'b0;
    n.sclA  = scl;
    n.sclB  = s.sclA;
    n.sclC  = s.sclB;
    n.sdaA  = sda;
    n.sdaB  = s.sdaA;
    n.sdaC  = s.sdaB;
    sclRise = s.sclB & ~s.sclC;
    sclFall = ~s.sclB & s.sclC;
    startC  = s.sclB & s.sclC & s.sdaC & ~s.sdaB;
    stopC   = s.sclB & s.sclC & ~s.sdaC & s.sdaB;
    // pointer steps after the write has been seen at its old value
    if (s.wr)
      n.ptr = s.ptr + 4'h1;
    if (!hostEn || stopC)
    begin
      n.st = SL_IDLE;
      n.oe = 1'b0;
    end
    else if (startC)
    begin
      n.st     = SL_ADDR;
      n.bitCnt = 4'h0;
      n.oe     = 1'b0;
    end
    else
      case (s.st)
        SL_ADDR, SL_WRB:
          if (sclRise)
          begin
            n.sh     = {s.sh[6:0], s.sdaB};
            n.bitCnt = s.bitCnt + 4'h1;
          end
          else if (sclFall && s.bitCnt == 4'h8)
          begin
            n.oe = 1'b1;
            if (s.st == SL_WRB)
            begin
              n.st = SL_WACK;
              if (s.gotPtr)
                n.wr = 1'b1;
              else
              begin
                n.ptr    = s.sh[7:4];
                n.gotPtr = 1'b1;
              end
            end
            else if (s.sh[7:1] == DEV_ADDR)
            begin
              n.st     = SL_AACK;
              n.rw     = s.sh[0];
              n.gotPtr = 1'b0;
            end
            else
            begin
              n.st = SL_IDLE;
              n.oe = 1'b0;
            end
          end
        SL_AACK, SL_RACK, SL_WACK:
          if (sclRise && s.st == SL_RACK)
            n.nack = s.sdaB;
          else if (sclFall)
          begin
            n.bitCnt = 4'h0;
            n.oe     = 1'b0;
            if (s.st == SL_RACK && s.nack)
              n.st = SL_IDLE;
            else if (s.st != SL_WACK && s.rw)
            begin
              n.st  = SL_RDB;
              n.sh  = rdData;
              n.ptr = s.ptr + 4'h1;
              n.oe  = ~rdData[7];
            end
            else
              n.st = SL_WRB;
          end
        SL_RDB:
          if (sclFall)
          begin
            if (s.bitCnt == 4'h7)
            begin
              n.st = SL_RACK;
              n.oe = 1'b0;
            end
            else
            begin
              n.sh     = {s.sh[6:0], 1'b0};
              n.oe     = ~s.sh[6];
              n.bitCnt = s.bitCnt + 4'h1;
            end
          end
        default:
          n.st = SL_IDLE;
      endcase
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      s <= '0;
    else
      s <= n;
  end

  // the line is only ever pulled low; the high level is the pull-up's
  assign sdaDrv  = 1'b0;
  assign sdaOe   = s.oe;
  assign regAddr = s.ptr;
  assign wrEn    = s.wr;
  assign wrData  = s.sh;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  host_off_a: assert property (!hostEn |=> !sdaOe)
    else $error("data line driven while host access is off");
  sda_drive_a: assert property (sdaOe |-> (s.st inside {SL_AACK, SL_WACK, SL_RDB}) && sdaDrv == 1'b0)
    else $error("data line pulled outside an ack or read bit");
  write_step_a: assert property (wrEn |=> regAddr == $past(regAddr) + 4'h1)
    else $error("register pointer did not step after a write");

endmodule

//--- test/brc_host_model.sv
// host-side model of the two-wire serial bus master
`timescale 1ns/100ps
module brc_host_model
(
  input  wire logic clk_sys,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull
);
  initial
  begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // ****
  // bus phases, a quarter period is 40 ns so the link stays at 160 ns
  // ****
  task automatic qtr(input int n);
    repeat (2 * n) @(posedge clk_sys);
  endtask

  task automatic startC();
    sdaPull <= 1'b0;
    qtr(1);
    scl <= 1'b1;
    qtr(2);
    sdaPull <= 1'b1;
    qtr(2);
    scl <= 1'b0;
  endtask

  task automatic stopC();
    qtr(1);
    sdaPull <= 1'b1;
    qtr(1);
    scl <= 1'b1;
    qtr(2);
    sdaPull <= 1'b0;
    qtr(2);
  endtask

  // data moves only while the clock is low
  task automatic bitOut(input logic b);
    qtr(1);
    sdaPull <= ~b;
    qtr(1);
    scl <= 1'b1;
    qtr(2);
    scl <= 1'b0;
  endtask

  task automatic bitIn(output logic b);
    qtr(1);
    sdaPull <= 1'b0;
    qtr(1);
    scl <= 1'b1;
    qtr(1);
    b = sdaWire;
    qtr(1);
    scl <= 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitOut(d[i]);
    bitIn(ack);
    ack = ~ack;
  endtask

  task automatic readByte(output logic [7:0] d, input logic ackIt);
    for (int i = 7; i >= 0; i--)
      bitIn(d[i]);
    bitOut(~ackIt);
  endtask
endmodule

//--- test/tb_brc_rtc_core.sv
// self-checking bench for the real-time clock core
`timescale 1ns/100ps
module tb_brc_rtc_core
  import brc_pkg::*;
;
  localparam logic [6:0] DEVA = 7'h5a;  // arbitrary bus address
  logic clk_sys = 1'b0;
  logic nrst, osc32k, oscRun, mainAboveDetect, mainAboveRelease, vddAboveHigh, vddAboveLow;
  logic scl, sdaPull, sdaDrv, sdaOe, useBackupSupply, mainSupplyLowOut, mainSupplyLowOe;
  logic irqNOut, irqNOe, khz32Out, ack, o;
  logic [7:0] rd;
  int n_fail = 0;
  int num_checks = 0;
  int oscCnt = 0;
  wire logic sdaWire = ~(sdaPull | sdaOe);

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    oscCnt <= oscCnt + 1;
    if (oscRun && oscCnt % 4 == 0)
      osc32k <= ~osc32k;
  end

  brc_rtc_core #(.RELEASE_CYC(50), .DEV_ADDR(DEVA)) dut (.clk_sys, .nrst, .osc32k, .mainAboveDetect,
    .mainAboveRelease, .vddAboveHigh, .vddAboveLow, .scl, .sda(sdaWire), .sdaDrv, .sdaOe,
    .useBackupSupply, .mainSupplyLowOut, .mainSupplyLowOe, .irqNOut, .irqNOe, .khz32Out);
  brc_host_model host (.clk_sys, .sdaWire, .scl, .sdaPull);

  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    host.startC();
    host.sendByte({DEVA, 1'b0}, ack);
    host.sendByte({a, 4'h0}, ack);
    host.sendByte(d, ack);
    host.stopC();
    chk(ack, 8'h01);
  endtask

  task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
    host.startC();
    host.sendByte({DEVA, 1'b0}, ack);
    host.sendByte({a, 4'h0}, ack);
    host.startC();
    host.sendByte({DEVA, 1'b1}, ack);
    host.readByte(d, 1'b0);
    host.stopC();
  endtask

  // ****
  // scenarios
  // ****
  task automatic resetRegs();
    rdReg(REG_CTRL2, rd);
    chk(rd, 8'h10);
    rdReg(REG_CTRL1, rd);
    chk(rd, 8'h00);
  endtask

  task automatic wrRead();
    logic [3:0] a [4] = '{REG_SEC, REG_YEAR, REG_WDAYS, REG_ADJ};
    logic [7:0] v [4] = '{8'h30, 8'h00, 8'h55, 8'h85};
    for (int i = 0; i < 4; i++)
    begin
      wrReg(a[i], v[i]);
      rdReg(a[i], rd);
      chk(rd, v[i]);
    end
    chk(sdaDrv, 8'h00);
  endtask

  task automatic supply();
    int n;
    mainAboveDetect <= 1'b0;
    mainAboveRelease <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(useBackupSupply, 8'h01);
    chk(mainSupplyLowOe, 8'h01);
    chk(mainSupplyLowOut, 8'h00);
    host.startC();
    host.sendByte({DEVA, 1'b0}, ack);
    host.stopC();
    chk(ack, 8'h00);
    mainAboveDetect <= 1'b1;
    mainAboveRelease <= 1'b1;
    n = 0;
    while (mainSupplyLowOe === 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    // two sync edges plus the shortened delay
    chk(8'(n >= 50 && n <= 56), 8'h01);
    if (n == 200)
      close_out();
    chk(useBackupSupply, 8'h00);
  endtask

  task automatic irqMode();
    wrReg(REG_CTRL1, {5'h00, CT_LOW});
    repeat (3) @(posedge clk_sys);
    chk(irqNOe, 8'h01);
    chk(irqNOut, 8'h00);
    wrReg(REG_CTRL1, 8'hc0);
    repeat (3) @(posedge clk_sys);
    chk(irqNOe, 8'h00);
    // seconds write restarts the divider, so the 2 Hz wave opens in its low phase
    wrReg(REG_SEC, 8'h00);
    wrReg(REG_CTRL1, {5'h00, CT_2HZ});
    repeat (3) @(posedge clk_sys);
    chk(irqNOe, 8'h01);
    rdReg(REG_CTRL2, rd);
    chk(8'(rd[C2_CTFG]), 8'h01);
    wrReg(REG_CTRL1, 8'hc0);
  endtask

  task automatic halt();
    wrReg(REG_CTRL2, 8'h20);
    rdReg(REG_CTRL2, rd);
    chk(rd, 8'h20);
    oscRun <= 1'b0;
    repeat (4100) @(posedge clk_sys);
    rdReg(REG_CTRL2, rd);
    chk(rd, 8'h00);
    oscRun <= 1'b1;
  endtask

  task automatic clkCopy();
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk_sys);
      o = osc32k;
      repeat (3) @(negedge clk_sys);
      chk(khz32Out, o);
    end
  endtask

  // a second cold start must undo the control writes and the power-on clear
  task automatic coldStart();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (60) @(posedge clk_sys);
    resetRegs();
  endtask

  initial
  begin
    nrst = 1'b0;
    osc32k = 1'b0;
    oscRun = 1'b1;
    mainAboveDetect = 1'b1;
    mainAboveRelease = 1'b1;
    vddAboveHigh = 1'b1;
    vddAboveLow = 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(mainSupplyLowOe, 8'h01);
    nrst <= 1'b1;
    repeat (60) @(posedge clk_sys);
    resetRegs();
    wrRead();
    supply();
    irqMode();
    halt();
    clkCopy();
    coldStart();
    close_out();
  end
endmodule
